// *** core/sbus_pkg.sv ***
/*
 * Constants shared by the satellite bus message decoder: framing codes,
 * command codes, address fields, status bit positions and reset values.
 * Assumes a byte-level link; bit timing and tone modulation live elsewhere.
 */
package sbus_pkg;

	// Framing bytes
	localparam logic [5:0] FRAME_CMD_TAG      = 6'h38;
	localparam logic [7:0] FRAME_OK           = 8'he4;
	localparam logic [7:0] FRAME_UNSUPPORTED  = 8'he5;
	localparam logic [7:0] FRAME_PARITY_ERR   = 8'he6;
	localparam logic [7:0] FRAME_UNKNOWN      = 8'he7;
	localparam int         FRAME_REPLY_BIT    = 1;
	localparam int         FRAME_REPEAT_BIT   = 0;

	// Address families
	localparam logic [3:0] FAMILY_WILDCARD    = 4'h0;
	localparam logic [3:0] FAMILY_REALLOC     = 4'h6;
	localparam logic [3:0] FAMILY_OEM         = 4'hf;
	localparam logic [7:0] FALLBACK_ADDRESS   = 8'h10;

	// Message sizes
	localparam int         MSG_MAX            = 6;
	localparam logic [2:0] LEN_SHORT          = 3'd3;
	localparam logic [2:0] LEN_DATA           = 3'd4;
	localparam logic [2:0] LEN_FREQ_MIN       = 3'd5;
	localparam logic [2:0] LEN_FREQ_MAX       = 3'd6;

	// Commands
	localparam logic [7:0] cmd_reset                  = 8'h00;
	localparam logic [7:0] cmd_clear_reset            = 8'h01;
	localparam logic [7:0] cmd_standby                = 8'h02;
	localparam logic [7:0] cmd_power_on               = 8'h03;
	localparam logic [7:0] cmd_set_contend            = 8'h04;
	localparam logic [7:0] cmd_addr_if_contend        = 8'h05;
	localparam logic [7:0] cmd_clear_contend          = 8'h06;
	localparam logic [7:0] cmd_addr_unless_contend    = 8'h07;
	localparam logic [7:0] cmd_move_if_contend        = 8'h08;
	localparam logic [7:0] cmd_move_unless_contend    = 8'h09;
	localparam logic [7:0] cmd_read_status            = 8'h10;
	localparam logic [7:0] cmd_read_config            = 8'h11;
	localparam logic [7:0] cmd_read_committed         = 8'h14;
	localparam logic [7:0] cmd_read_uncommitted       = 8'h15;
	localparam logic [7:0] cmd_select_low_oscillator  = 8'h20;
	localparam logic [7:0] cmd_select_option_second   = 8'h27;
	localparam logic [7:0] cmd_select_sw1_input_first = 8'h28;
	localparam logic [7:0] cmd_select_sw4_second      = 8'h2f;
	localparam logic [7:0] cmd_sleep                  = 8'h30;
	localparam logic [7:0] cmd_awake                  = 8'h31;
	localparam logic [7:0] cmd_write_committed_group  = 8'h38;
	localparam logic [7:0] cmd_write_uncommitted_group = 8'h39;
	localparam logic [7:0] cmd_read_analogue_first    = 8'h40;
	localparam logic [7:0] cmd_read_analogue_second   = 8'h41;
	localparam logic [7:0] cmd_write_analogue_first   = 8'h48;
	localparam logic [7:0] cmd_write_analogue_second  = 8'h49;
	localparam logic [7:0] cmd_read_freq_bcd          = 8'h50;
	localparam logic [7:0] cmd_read_freq_entry_current = 8'h51;
	localparam logic [7:0] cmd_read_freq_entry_low    = 8'h52;
	localparam logic [7:0] cmd_read_freq_entry_high   = 8'h53;
	localparam logic [7:0] cmd_write_channel_freq     = 8'h58;
	localparam logic [7:0] cmd_mover_halt             = 8'h60;
	localparam logic [7:0] cmd_limits_off             = 8'h63;
	localparam logic [7:0] cmd_read_mover_status      = 8'h64;

	// Status reply bits
	localparam int STAT_RESET_BIT   = 0;
	localparam int STAT_STANDBY_BIT = 1;
	localparam int STAT_CONTEND_BIT = 2;
	localparam int STAT_SLEEP_BIT   = 3;

	// Reset values
	localparam logic [3:0] SW_RESET       = 4'h0;
	localparam logic [7:0] ANALOGUE_RESET = 8'h00;

endpackage : sbus_pkg

// *** core/odd_parity.sv ***
/*
 * Odd parity bit for one byte.
 * Purely combinational; the caller registers the result where needed.
 */
`timescale 1ns/100ps
`default_nettype none
module odd_parity (
	input  wire logic [7:0] data,   // Byte to protect
	output logic            par     // Bit that makes the ones count odd
);
	assign par = ~^data;
endmodule : odd_parity
`default_nettype wire

// *** core/skid_buffer.sv ***
/*
 * Two-entry buffer with valid/ready on both sides and registered outputs.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module skid_buffer #(
	parameter int W = 10
) (
	input  wire logic         clk,        // Clock
	input  wire logic         rstn,       // Synchronous reset, active low
	input  wire logic         in_valid,   // Word offered
	input  wire logic [W-1:0] in_data,    // Word in
	output logic              in_ready,   // Room for a word
	output logic              out_valid,  // Word held at output
	output logic [W-1:0]      out_data,   // Word out
	input  wire logic         out_ready   // Receiver takes the word
);
	typedef struct packed {
		logic         ov;
		logic [W-1:0] od;
		logic         sv;
		logic [W-1:0] sd;
	} skid_t;

	skid_t r, n;
	logic  push;

	always_comb begin
		n    = r;
		push = in_valid & ~r.sv;
		if (!r.ov || out_ready) begin
			if (r.sv) begin
				n.od = r.sd;
				n.ov = 1'b1;
				n.sv = 1'b0;
			end else begin
				n.od = push ? in_data : r.od;
				n.ov = push;
			end
		end else if (push) begin
			n.sd = in_data;
			n.sv = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			r <= '0;
		else
			r <= n;
	end

	assign in_ready  = ~r.sv;
	assign out_valid = r.ov;
	assign out_data  = r.od;
endmodule : skid_buffer
`default_nettype wire

// *** core/sbus_decoder.sv ***
/*
 * Slave-side message decoder for a single-master satellite control bus.
 * Collects a command message byte by byte, checks odd parity, decodes
 * framing, address and command, updates the peripheral controls and
 * queues the reply bytes through a two-entry buffer.
 * Assumes a bit-level receiver/transmitter delivering whole bytes with
 * their parity bit and an end-of-message mark, all synchronous to clk.
 */
// Operation
// - Master message is framing, address, command, then data; each byte odd parity.
// - Reply is one framing byte plus optional data, each with odd parity.
// - Reply bytes are queued back to back until the last one.
// - Framing E0 to E3 decode reply wanted and repeat flags; the repeat flag (bit 0) is ignored.
// - Successful reply uses E4; valid but unimplemented command uses E5.
// - Parity error replies E6; unrecognised command replies E7.
// - Address 00 reaches every slave.
// - Upper address nibble is family, lower nibble is sub-type.
// - Family six is only for reassigned addresses, never a factory address.
// - Family fifteen messages are left to manufacturer extensions.
// - Command 02 enters standby, 03 powers the peripheral back on.
// - Contention flag set by 04, cleared by 06; 05/07 return address conditionally.
// - Commands 08 and 09 load a new address depending on contention flag.
// - Commands 10, 11, 14, 15 return status, config and switch states.
// - Commands 20 to 27 pick oscillator, polarisation, position, option.
// - Commands 28 to 2F pick input A or B of switches one to four.
// - After 30 only 31 is obeyed; 31 restores normal handling.
// - Commands 38 and 39 update committed and uncommitted groups.
// - 48/49 load analogue values; 40/41 read them back.
// - 50 returns BCD frequency; 51 to 53 return table entry numbers.
// - 58 takes a BCD channel frequency in a five or six byte message.
// - 60 halts the mover, 63 disables soft limits, 64 reads mover status.
// - A zero address nibble is a wildcard for that nibble.
// - Group writes clear by the high nibble, then set by the low nibble.
`timescale 1ns/100ps
`default_nettype none
module sbus_decoder (
	input  wire logic        clk,              // Clock, 125 MHz
	input  wire logic        rstn,             // Synchronous reset, active low
	input  wire logic        rx_valid,         // Received byte present
	input  wire logic [7:0]  rx_data,          // Received byte
	input  wire logic        rx_par,           // Its parity bit
	input  wire logic        rx_end,           // Byte is last of message
	output logic             rx_ready,         // Decoder takes bytes
	output logic             tx_valid,         // Reply byte present
	output logic [7:0]       tx_data,          // Reply byte
	output logic             tx_par,           // Its odd parity bit
	output logic             tx_last,          // Byte ends the reply
	input  wire logic        tx_ready,         // Transmitter takes byte
	input  wire logic [7:0]  factory_address,  // Strapped slave address
	input  wire logic [7:0]  config_flags,     // Hardware configuration
	input  wire logic [7:0]  mover_status,     // Positioner status byte
	input  wire logic [15:0] freq_bcd,         // Current oscillator, BCD
	input  wire logic [7:0]  freq_entry_low,   // Low oscillator entry
	input  wire logic [7:0]  freq_entry_high,  // High oscillator entry
	output logic             periph_power,     // Peripheral supply on
	output logic [3:0]       committed_sw,     // Osc, pol, position, option
	output logic [3:0]       uncommitted_sw,   // Switches one to four
	output logic [7:0]       analogue_first,   // Analogue value A0
	output logic [7:0]       analogue_second,  // Analogue value A1
	output logic [23:0]      chan_freq,        // Channel frequency, BCD
	output logic             mover_halt,       // Stop pulse
	output logic             limits_off,       // Soft limits off pulse
	output logic [7:0]       own_address,      // Current slave address
	output logic             reset_flag,       // Reset flag
	output logic             contention_flag,  // Contention flag
	output logic             asleep            // Ignoring commands
);
	import sbus_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_SEND = 2'b11
	} state_t;

	typedef struct packed {
		state_t                 st;
		logic [2:0]             cnt;
		logic [MSG_MAX-1:0][7:0] msg;
		logic                   perr;
		logic                   addr_ok;
		logic [7:0]             addr;
		logic                   rst_flag;
		logic                   cont;
		logic                   sleep;
		logic                   pwr;
		logic [3:0]             sw0;
		logic [3:0]             sw1;
		logic [7:0]             a0;
		logic [7:0]             a1;
		logic [23:0]            freq;
		logic                   halt;
		logic                   lim_off;
		logic                   rx_rdy;
		logic [1:0]             rlen;
		logic [1:0]             ridx;
		logic [2:0][7:0]        rep;
	} core_t;

	localparam core_t CORE_RESET = '{
		st: ST_IDLE, cnt: 3'd0, msg: '0, perr: 1'b0, addr_ok: 1'b0,
		addr: FALLBACK_ADDRESS, rst_flag: 1'b1, cont: 1'b0, sleep: 1'b0,
		pwr: 1'b1, sw0: SW_RESET, sw1: SW_RESET, a0: ANALOGUE_RESET,
		a1: ANALOGUE_RESET, freq: '0, halt: 1'b0, lim_off: 1'b0,
		rx_rdy: 1'b0, rlen: 2'd0, ridx: 2'd0, rep: '0
	};

	core_t      r, n;
	logic       rx_par_exp;
	logic       tx_par_new;
	logic       buf_in_ready;
	logic       buf_out_valid;
	logic [9:0] buf_out_data;
	logic       push;
	logic       last_rep;
	logic [7:0] fr, ad, cm, d;
	logic       frame_ok, want_reply, match;
	logic       known, supported, len_ok, do_reply;
	logic [2:0] need_len;
	logic [7:0] status_byte;

	odd_parity u_rx_par (
		.data (rx_data),
		.par  (rx_par_exp)
	);

	odd_parity u_tx_par (
		.data (r.rep[r.ridx]),
		.par  (tx_par_new)
	);

	skid_buffer #(.W(10)) u_reply_buf (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (r.st == ST_SEND),
		.in_data   ({r.rep[r.ridx], tx_par_new, last_rep}),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_data  (buf_out_data),
		.out_ready (tx_ready)
	);

	always_comb begin
		n          = r;
		n.halt     = 1'b0;
		n.lim_off  = 1'b0;
		fr         = r.msg[0];
		ad         = r.msg[1];
		cm         = r.msg[2];
		d          = r.msg[3];
		frame_ok   = fr[7:2] == FRAME_CMD_TAG;
		want_reply = fr[FRAME_REPLY_BIT];
		match      = (ad[7:4] == FAMILY_WILDCARD || ad[7:4] == r.addr[7:4])
			&& (ad[3:0] == 4'h0 || ad[3:0] == r.addr[3:0]);
		status_byte = '0;
		status_byte[STAT_RESET_BIT]   = r.rst_flag;
		status_byte[STAT_STANDBY_BIT] = ~r.pwr;
		status_byte[STAT_CONTEND_BIT] = r.cont;
		status_byte[STAT_SLEEP_BIT]   = r.sleep;
		push     = (r.st == ST_SEND) && buf_in_ready;
		last_rep = r.ridx == r.rlen - 2'd1;
		known     = 1'b1;
		supported = 1'b1;
		need_len  = LEN_SHORT;
		do_reply  = 1'b1;

		unique case (cm) inside
			[8'h00:8'h07], 8'h10, 8'h11, 8'h14, 8'h15, [8'h20:8'h31],
			8'h40, 8'h41, [8'h50:8'h53], 8'h60, 8'h63, 8'h64: begin
				need_len = LEN_SHORT;
			end
			8'h08, 8'h09, 8'h38, 8'h39, 8'h48, 8'h49: begin
				need_len = LEN_DATA;
			end
			8'h58: begin
				need_len = LEN_FREQ_MIN;
			end
			8'h0f, 8'h16, 8'h17, 8'h3a, 8'h3b, 8'h59, 8'h61, 8'h62,
			[8'h65:8'h6f]: begin
				supported = 1'b0;
			end
			default: begin
				known = 1'b0;
			end
		endcase
		len_ok = (cm == cmd_write_channel_freq)
			? (r.cnt == LEN_FREQ_MIN || r.cnt == LEN_FREQ_MAX)
			: (!supported || r.cnt == need_len);

		unique case (r.st)
			ST_IDLE: begin
				if (!r.addr_ok) begin
					n.addr_ok = 1'b1;
					n.rx_rdy  = 1'b1;
					n.addr    = (factory_address[7:4] == FAMILY_REALLOC)
						? FALLBACK_ADDRESS : factory_address;
				end else if (rx_valid && r.rx_rdy) begin
					if (r.cnt < 3'(MSG_MAX))
						n.msg[r.cnt] = rx_data;
					if (rx_par != rx_par_exp)
						n.perr = 1'b1;
					n.cnt = (r.cnt == 3'd7) ? r.cnt : r.cnt + 3'd1;
					if (rx_end) begin
						n.st     = ST_EXEC;
						n.rx_rdy = 1'b0;
					end
				end
			end
			ST_EXEC: begin
				n.st     = ST_IDLE;
				n.rx_rdy = 1'b1;
				n.cnt    = 3'd0;
				n.perr   = 1'b0;
				n.ridx   = 2'd0;
				n.rlen   = 2'd1;
				n.rep    = '0;
				n.rep[0] = FRAME_OK;
				if (!frame_ok || r.cnt < LEN_SHORT || !match
					|| ad[7:4] == FAMILY_OEM) begin
					do_reply = 1'b0;
				end else if (r.sleep && cm != cmd_awake) begin
					do_reply = 1'b0;
				end else if (r.perr) begin
					n.rep[0] = FRAME_PARITY_ERR;
				end else if (!known || !len_ok) begin
					n.rep[0] = FRAME_UNKNOWN;
				end else if (!supported) begin
					n.rep[0] = FRAME_UNSUPPORTED;
				end else begin
					unique case (cm) inside
						cmd_reset: begin
							n.rst_flag = 1'b1;
							n.cont     = 1'b0;
							n.sleep    = 1'b0;
							n.pwr      = 1'b1;
							n.sw0      = SW_RESET;
							n.sw1      = SW_RESET;
							n.a0       = ANALOGUE_RESET;
							n.a1       = ANALOGUE_RESET;
						end
						cmd_clear_reset:   n.rst_flag = 1'b0;
						cmd_standby:       n.pwr = 1'b0;
						cmd_power_on:      n.pwr = 1'b1;
						cmd_set_contend:   n.cont = 1'b1;
						cmd_clear_contend: n.cont = 1'b0;
						cmd_addr_if_contend, cmd_addr_unless_contend: begin
							do_reply = r.cont == (cm == cmd_addr_if_contend);
							n.rep[1] = r.addr;
							n.rlen   = 2'd2;
						end
						cmd_move_if_contend: begin
							if (r.cont)
								n.addr = d;
						end
						cmd_move_unless_contend: begin
							if (!r.cont)
								n.addr = d;
						end
						cmd_read_status, cmd_read_config,
						cmd_read_committed, cmd_read_uncommitted: begin
							n.rlen = 2'd2;
							unique case (cm)
								cmd_read_status:    n.rep[1] = status_byte;
								cmd_read_config:    n.rep[1] = config_flags;
								cmd_read_committed: n.rep[1] = {4'h0, r.sw0};
								default:            n.rep[1] = {4'h0, r.sw1};
							endcase
						end
						[cmd_select_low_oscillator:cmd_select_option_second]:
							n.sw0[cm[1:0]] = cm[2];
						[cmd_select_sw1_input_first:cmd_select_sw4_second]:
							n.sw1[cm[1:0]] = cm[2];
						cmd_sleep: n.sleep = 1'b1;
						cmd_awake: n.sleep = 1'b0;
						cmd_write_committed_group:
							n.sw0 = (r.sw0 & ~d[7:4]) | d[3:0];
						cmd_write_uncommitted_group:
							n.sw1 = (r.sw1 & ~d[7:4]) | d[3:0];
						cmd_write_analogue_first:  n.a0 = d;
						cmd_write_analogue_second: n.a1 = d;
						cmd_read_analogue_first, cmd_read_analogue_second: begin
							n.rlen   = 2'd2;
							n.rep[1] = cm[0] ? r.a1 : r.a0;
						end
						cmd_read_freq_bcd: begin
							n.rlen   = 2'd3;
							n.rep[1] = freq_bcd[15:8];
							n.rep[2] = freq_bcd[7:0];
						end
						[cmd_read_freq_entry_current:cmd_read_freq_entry_high]: begin
							n.rlen = 2'd2;
							if (cm == cmd_read_freq_entry_low)
								n.rep[1] = freq_entry_low;
							else if (cm == cmd_read_freq_entry_high || r.sw0[0])
								n.rep[1] = freq_entry_high;
							else
								n.rep[1] = freq_entry_low;
						end
						cmd_write_channel_freq: begin
							n.freq = {r.msg[3],
								r.msg[4],
								(r.cnt == LEN_FREQ_MAX) ? r.msg[5] : 8'h00};
						end
						cmd_mover_halt: n.halt    = 1'b1;
						cmd_limits_off: n.lim_off = 1'b1;
						cmd_read_mover_status: begin
							n.rlen   = 2'd2;
							n.rep[1] = mover_status;
						end
						default: begin
							do_reply = 1'b1;
						end
					endcase
				end
				if (do_reply && want_reply) begin
					n.st     = ST_SEND;
					n.rx_rdy = 1'b0;
				end
			end
			ST_SEND: begin
				if (push) begin
					if (last_rep) begin
						n.st     = ST_IDLE;
						n.rx_rdy = 1'b1;
					end else begin
						n.ridx = r.ridx + 2'd1;
					end
				end
			end
			default: begin
				n = CORE_RESET;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			r <= CORE_RESET;
		else
			r <= n;
	end

	assign rx_ready        = r.rx_rdy;
	assign tx_valid        = buf_out_valid;
	assign tx_data         = buf_out_data[9:2];
	assign tx_par          = buf_out_data[1];
	assign tx_last         = buf_out_data[0];
	assign periph_power    = r.pwr;
	assign committed_sw    = r.sw0;
	assign uncommitted_sw  = r.sw1;
	assign analogue_first  = r.a0;
	assign analogue_second = r.a1;
	assign chan_freq       = r.freq;
	assign mover_halt      = r.halt;
	assign limits_off      = r.lim_off;
	assign own_address     = r.addr;
	assign reset_flag      = r.rst_flag;
	assign contention_flag = r.cont;
	assign asleep          = r.sleep;
endmodule : sbus_decoder
`default_nettype wire

// *** bench/sbus_decoder_chk.sv ***
/* Port assertions for the satellite bus decoder.
   Bound onto sbus_decoder from the testbench top file. */
`timescale 1ns/100ps
`default_nettype none
module sbus_decoder_chk (
	input wire logic       clk,              // Clock
	input wire logic       rstn,             // Reset
	input wire logic       rx_valid,         // Byte offered
	input wire logic       rx_end,           // Last byte
	input wire logic       rx_ready,         // Byte taken
	input wire logic       tx_valid,         // Reply byte
	input wire logic [7:0] tx_data,          // Reply data
	input wire logic       tx_par,           // Reply parity
	input wire logic       tx_last,          // Reply end
	input wire logic       tx_ready,         // Reply taken
	input wire logic       mover_halt,       // Pulse
	input wire logic       limits_off,       // Pulse
	input wire logic [3:0] committed_sw,     // Switches
	input wire logic [3:0] uncommitted_sw,   // Switches
	input wire logic       asleep,           // Sleep
	input wire logic       reset_flag,       // Flag
	input wire logic       periph_power,     // Supply
	input wire logic       contention_flag   // Flag
);
	logic first_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Next reply byte is a framing byte
	always_ff @(posedge clk) begin
		if (!rstn) first_r <= 1'b1;
		else if (tx_valid && tx_ready) first_r <= tx_last;
	end
	frame_code_a: assert property (tx_valid && first_r |-> tx_data[7:2] == 6'h39)
		else $error("reply framing code wrong");
	par_odd_a: assert property (tx_valid |-> ^{tx_data, tx_par})
		else $error("reply parity not odd");
	tx_hold_a: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("reply byte dropped");
	rx_busy_a: assert property (rx_valid && rx_ready && rx_end |=> !rx_ready)
		else $error("still taking bytes after message end");
	halt_pulse_a: assert property (mover_halt |=> !mover_halt)
		else $error("halt pulse too long");
	limits_pulse_a: assert property (limits_off |=> !limits_off)
		else $error("limits pulse too long");
	sleep_hold_a: assert property (asleep |=> $stable({committed_sw, uncommitted_sw}))
		else $error("switches changed while asleep");
	reset_val_a: assert property ($rose(rstn) |-> reset_flag && periph_power
		&& !contention_flag && !asleep) else $error("bad state after reset");
endmodule : sbus_decoder_chk
`default_nettype wire

// *** bench/sbus_master.sv ***
/* Bus master model: sends command bytes, takes reply bytes.
   Tasks are called just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module sbus_master (
	input wire logic       clk,       // Clock
	input wire logic       stall,     // Hold off replies
	output logic           rx_valid,  // Byte offered
	output logic [7:0]     rx_data,   // Byte
	output logic           rx_par,    // Parity
	output logic           rx_end,    // Last byte
	input wire logic       rx_ready,  // Byte taken
	input wire logic       tx_valid,  // Reply byte
	input wire logic [7:0] tx_data,   // Reply data
	input wire logic       tx_last,   // Reply end
	output logic           tx_ready   // Reply taken
);
	assign tx_ready = !stall;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_par = 1'b0;
		rx_end = 1'b0;
	end
	// Bytes back to back, each held until taken
	task automatic send(input logic [47:0] m, input int n, input logic bad);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= m[47-8*i -: 8];
			rx_par <= (~^m[47-8*i -: 8]) ^ (bad && i == 2);
			rx_end <= (i == n - 1);
			do @(posedge clk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		rx_end <= 1'b0;
	endtask : send
	task automatic recv(output logic [23:0] r, output int k);
		r = 24'h000000;
		k = 0;
		for (int t = 0; t < 40; t++) begin
			@(posedge clk);
			if (tx_valid === 1'b1 && tx_ready) begin
				r = {r[15:0], tx_data};
				k++;
				if (tx_last === 1'b1) break;
			end
		end
	endtask : recv
endmodule : sbus_master
`default_nettype wire

// *** bench/tb_sbus_decoder.sv ***
/* Self-checking testbench for sbus_decoder with a master model.
   Needs sbus_pkg, the design files and the checker. */
`timescale 1ns/100ps
`default_nettype none
module tb_sbus_decoder;
	import sbus_pkg::*;
	logic clk, rstn, stall, rx_valid, rx_par, rx_end, rx_ready, tx_valid, tx_par, tx_last;
	logic tx_ready, periph_power, mover_halt, limits_off, reset_flag, contention_flag, asleep;
	logic [7:0] rx_data, tx_data, factory_address, config_flags, mover_status, own_address;
	logic [7:0] freq_entry_low, freq_entry_high, analogue_first, analogue_second;
	logic [15:0] freq_bcd;
	logic [3:0] committed_sw, uncommitted_sw;
	logic [23:0] chan_freq;
	int n_fail, compares, cyc, n_pulse;
	sbus_decoder u_dut (.clk, .rstn, .rx_valid, .rx_data, .rx_par, .rx_end, .rx_ready,
		.tx_valid, .tx_data, .tx_par, .tx_last, .tx_ready, .factory_address, .config_flags,
		.mover_status, .freq_bcd, .freq_entry_low, .freq_entry_high, .periph_power,
		.committed_sw, .uncommitted_sw, .analogue_first, .analogue_second, .chan_freq,
		.mover_halt, .limits_off, .own_address, .reset_flag, .contention_flag, .asleep);
	sbus_master u_m (.clk, .stall, .rx_valid, .rx_data, .rx_par, .rx_end, .rx_ready,
		.tx_valid, .tx_data, .tx_last, .tx_ready);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cyc++;
		if (mover_halt === 1'b1) n_pulse++;
		if (limits_off === 1'b1) n_pulse += 16;
		if (cyc == 10000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic x(input logic [7:0] f, a, c, input logic [23:0] d, input int n,
			input logic [23:0] e, input int en, input logic bad = 1'b0);
		logic [23:0] r;
		int k;
		u_m.send({f, a, c, d}, n, bad);
		u_m.recv(r, k);
		chk(k, en);
		chk(r, e);
	endtask : x
	task automatic t_basic;
		x(8'he2, 8'h11, 8'h10, 0, 3, {FRAME_OK, 8'h01}, 2);
		x(8'he3, 8'h11, 8'h11, 0, 3, {FRAME_OK, 8'h5a}, 2);
		x(8'he2, 8'h11, 8'h01, 0, 3, FRAME_OK, 1);
		x(8'he2, 8'h00, 8'h10, 0, 3, {FRAME_OK, 8'h00}, 2);
		x(8'he2, 8'h01, 8'h10, 0, 3, {FRAME_OK, 8'h00}, 2);
		x(8'he2, 8'h21, 8'h10, 0, 3, 0, 0);
		x(8'he2, 8'hf1, 8'h10, 0, 3, 0, 0);
		x(8'he0, 8'h11, 8'h10, 0, 3, 0, 0);
		x(8'he2, 8'h11, 8'h10, 0, 3, FRAME_PARITY_ERR, 1, 1'b1);
		x(8'he2, 8'h11, 8'h12, 0, 3, FRAME_UNKNOWN, 1);
		x(8'he2, 8'h11, 8'h16, 0, 3, FRAME_UNSUPPORTED, 1);
		x(8'he0, 8'h11, 8'h02, 0, 3, 0, 0);
		chk(periph_power, 1'b0);
		x(8'he2, 8'h11, 8'h10, 0, 3, {FRAME_OK, 8'h02}, 2);
		x(8'he0, 8'h11, 8'h03, 0, 3, 0, 0);
		chk(periph_power, 1'b1);
		$display("test basic done");
	endtask : t_basic
	task automatic t_switch;
		logic [3:0] cs, us;
		cs = 4'h0;
		us = 4'h0;
		for (int c = 8'h20; c <= 8'h2f; c++) begin
			x(8'he0, 8'h10, 8'(c), 0, 3, 0, 0);
			if (c < 8'h28) cs[c[1:0]] = c[2];
			else us[c[1:0]] = c[2];
			chk({committed_sw, uncommitted_sw}, {cs, us});
		end
		x(8'he2, 8'h11, 8'h38, 24'h350000, 4, FRAME_OK, 1);
		chk(committed_sw, 4'hd);
		x(8'he2, 8'h11, 8'h14, 0, 3, {FRAME_OK, 8'h0d}, 2);
		x(8'he2, 8'h11, 8'h39, 24'hf20000, 4, FRAME_OK, 1);
		x(8'he2, 8'h11, 8'h15, 0, 3, {FRAME_OK, 8'h02}, 2);
		x(8'he2, 8'h11, 8'h38, 0, 3, FRAME_UNKNOWN, 1);
		x(8'he0, 8'h11, 8'h00, 0, 3, 0, 0);
		chk({reset_flag, committed_sw, uncommitted_sw}, 9'h100);
		x(8'he0, 8'h11, 8'h48, 24'hab0000, 4, 0, 0);
		x(8'he0, 8'h11, 8'h49, 24'h5c0000, 4, 0, 0);
		x(8'he2, 8'h11, 8'h40, 0, 3, {FRAME_OK, 8'hab}, 2);
		x(8'he2, 8'h11, 8'h41, 0, 3, {FRAME_OK, 8'h5c}, 2);
		chk({analogue_first, analogue_second}, 16'hab5c);
		x(8'he0, 8'h11, 8'h30, 0, 3, 0, 0);
		x(8'he0, 8'h11, 8'h24, 0, 3, 0, 0);
		x(8'he2, 8'h11, 8'h10, 0, 3, 0, 0);
		chk({asleep, committed_sw}, 5'h10);
		x(8'he2, 8'h11, 8'h31, 0, 3, FRAME_OK, 1);
		chk(asleep, 1'b0);
		$display("test switch done");
	endtask : t_switch
	task automatic t_freq;
		logic [23:0] r;
		int k;
		stall <= 1'b1;
		u_m.send({8'he2, 8'h11, 8'h50, 24'h0}, 3, 1'b0);
		repeat (8) @(posedge clk);
		chk({tx_valid, rx_ready}, 2'b10);
		stall <= 1'b0;
		u_m.recv(r, k);
		chk(k, 3);
		chk(r, {FRAME_OK, freq_bcd});
		x(8'he2, 8'h11, 8'h51, 0, 3, {FRAME_OK, freq_entry_low}, 2);
		x(8'he2, 8'h11, 8'h53, 0, 3, {FRAME_OK, freq_entry_high}, 2);
		x(8'he0, 8'h11, 8'h58, 24'h126500, 6, 0, 0);
		chk(chan_freq, 24'h126500);
		x(8'he0, 8'h11, 8'h58, 24'h134000, 5, 0, 0);
		chk(chan_freq, 24'h134000);
		x(8'he2, 8'h11, 8'h60, 0, 3, FRAME_OK, 1);
		chk(n_pulse, 1);
		x(8'he2, 8'h11, 8'h63, 0, 3, FRAME_OK, 1);
		chk(n_pulse, 17);
		x(8'he2, 8'h11, 8'h64, 0, 3, {FRAME_OK, 8'h3c}, 2);
		$display("test freq done");
	endtask : t_freq
	task automatic t_contend;
		x(8'he0, 8'h11, 8'h04, 0, 3, 0, 0);
		x(8'he2, 8'h11, 8'h05, 0, 3, {FRAME_OK, 8'h11}, 2);
		x(8'he2, 8'h11, 8'h07, 0, 3, 0, 0);
		x(8'he0, 8'h11, 8'h09, 24'h220000, 4, 0, 0);
		chk(own_address, 8'h11);
		x(8'he0, 8'h11, 8'h08, 24'h150000, 4, 0, 0);
		chk(own_address, 8'h15);
		x(8'he0, 8'h15, 8'h06, 0, 3, 0, 0);
		x(8'he2, 8'h15, 8'h07, 0, 3, {FRAME_OK, 8'h15}, 2);
		$display("test contend done");
	endtask : t_contend
	// Mid-run reset with a strap in the reserved family
	task automatic t_realloc;
		factory_address <= 8'h63;
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk(own_address, FALLBACK_ADDRESS);
		x(8'he2, 8'h63, 8'h10, 0, 3, 0, 0);
		x(8'he2, 8'h10, 8'h10, 0, 3, {FRAME_OK, 8'h01}, 2);
		$display("test realloc done");
	endtask : t_realloc
	initial begin
		rstn = 1'b0;
		stall = 1'b0;
		factory_address = 8'h11;
		config_flags = 8'h5a;
		mover_status = 8'h3c;
		freq_bcd = 16'h1060;
		freq_entry_low = 8'h03;
		freq_entry_high = 8'h07;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_basic();
		t_switch();
		t_freq();
		t_contend();
		t_realloc();
		complete_run();
	end
endmodule : tb_sbus_decoder
bind sbus_decoder sbus_decoder_chk u_chk (.clk, .rstn, .rx_valid, .rx_end, .rx_ready,
	.tx_valid, .tx_data, .tx_par, .tx_last, .tx_ready, .mover_halt, .limits_off,
	.committed_sw, .uncommitted_sw, .asleep, .reset_flag, .periph_power, .contention_flag);
`default_nettype wire
